// File: rtl/iob_host_ctrl.sv
// host end of the byte-wide handshaked i/o bus, ordered over axi4-lite
`default_nettype none
module iob_host_ctrl
  import iob_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned BUF_DEPTH = 256
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire iob_in_t bus_in,
  output iob_out_t bus_out
);
  localparam int unsigned PTR_W = $clog2(BUF_DEPTH);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_DRIVE, S_WAIT_SYN, S_WAIT_REL, S_GAP} iob_state_t;

  // ****************************************
  // helpers
  // ****************************************
  // select line for an operation and its phase
  function automatic logic [2:0] line_of(input iob_op_t op, input logic data_ph);
    unique case (op)
      OP_ADDR: line_of = L_ADDR;
      OP_CMD: line_of = L_CMD;
      OP_WRITE: line_of = L_DA;
      OP_STATUS: line_of = L_SR;
      OP_READ: line_of = L_DR;
      OP_ACK: line_of = L_ACK;
      OP_RDS, OP_RBLK: line_of = data_ph ? L_DR : L_SR;
      default: line_of = data_ph ? L_DA : L_SR;
    endcase
  endfunction

  // register decode shared by both bus halves
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = a inside {REG_CMD, REG_STAT, REG_CTRL, REG_BPTR, REG_BDATA};
  endfunction

  // ****************************************
  // state
  // ****************************************
  iob_in_t sync1_r; // first synchroniser stage
  iob_in_t sync2_r; // second stage, only this one is read
  iob_state_t state_r;
  iob_op_t op_r; // operation under way
  logic [7:0] byte_r; // outbound byte of the command
  logic [8:0] cnt_r; // bytes left in a block
  logic ph_data_r; // composite op is in its transfer phase
  logic halt_r; // status showed an error bit
  logic skip_r; // last composite op moved its byte
  logic busy_r;
  logic [GAP_W-1:0] gap_r;
  logic [PTR_W-1:0] ptr_r; // buffer index
  logic [7:0] result_r; // last returned byte
  logic clr_r; // system clear request
  logic [7:0] dal_r;
  logic [7:0] cl_r;
  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] buf_mem [BUF_DEPTH]; // block data, one byte per slot

  // ****************************************
  // decoding
  // ****************************************
  wire logic syn_on = ~sync2_r.syn_n;
  wire logic [7:0] drl_val = ~sync2_r.drl_n;
  wire logic composite = op_r inside {OP_RDS, OP_WDS, OP_RBLK, OP_WBLK};
  wire logic blk = op_r inside {OP_RBLK, OP_WBLK};
  wire logic wr_type = op_r inside {OP_WDS, OP_WBLK};
  wire logic stat_ph = composite && !ph_data_r;
  wire logic [2:0] cur_line = line_of(op_r, ph_data_r);
  wire logic capture = cur_line inside {L_SR, L_DR, L_ACK};
  wire logic st_err = drl_val[SB_EX] | drl_val[SB_EOM] | drl_val[SB_DU];
  wire logic hold_busy = stat_ph && !st_err && drl_val[SB_BUSY];
  wire logic [7:0] cur_byte = (wr_type && blk) ? buf_mem[ptr_r] :
    (op_r inside {OP_ADDR, OP_CMD, OP_WRITE, OP_WDS}) ? byte_r : 8'h00;
  wire logic wr_ok = awready_r && wstrb[0];
  wire logic cmd_wr = wr_ok && awaddr == REG_CMD && state_r == S_IDLE && wdata[3:0] <= OP_WBLK;
  wire logic fsm_inc = state_r == S_WAIT_SYN && syn_on && blk && ph_data_r;
  wire logic sw_ptr = !busy_r && wr_ok && awaddr == REG_BPTR;
  wire logic sw_bwr = !busy_r && wr_ok && awaddr == REG_BDATA;
  wire logic sw_brd = !busy_r && arready_r && araddr == REG_BDATA;
  wire logic [PTR_W-1:0] ptr_inc = PTR_W'(ptr_r + 1'b1);
  wire logic [PTR_W-1:0] ptr_nxt = fsm_inc ? ptr_inc : sw_ptr ? wdata[PTR_W-1:0] :
    (sw_bwr || sw_brd) ? ptr_inc : ptr_r;
  wire logic [31:0] stat_word = {7'h00, cnt_r, result_r, 4'h0, halt_r, ~sync2_r.atn_n, skip_r, busy_r};
  wire logic [31:0] rd_word = (araddr == REG_STAT) ? stat_word :
    (araddr == REG_CTRL) ? {31'h0, clr_r} :
    (araddr == REG_BPTR) ? {{(32 - PTR_W){1'b0}}, ptr_r} :
    (araddr == REG_BDATA) ? {24'h0, buf_mem[ptr_r]} : 32'h0;

  assign awready = awready_r;
  assign wready = awready_r; // address and data are taken together
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign bus_out = '{dal_n: dal_r, cl_n: cl_r, clear_n: ~clr_r};

  // ****************************************
  // pin synchroniser
  // ****************************************
  // bus lines arrive without a clock, so two stages guard against metastability
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '1;
      sync2_r <= '1;
    end
    else
    begin
      sync1_r <= bus_in;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // one write and one read at a time; ready is a single-cycle pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
      clr_r <= CTRL_RST;
      ptr_r <= '0;
    end
    else
    begin
      awready_r <= awvalid && wvalid && !awready_r && !bvalid_r;
      arready_r <= arvalid && !arready_r && !rvalid_r;
      ptr_r <= ptr_nxt;
      if (awready_r)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= addr_ok(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid_r <= 1'b0;
      if (arready_r)
      begin
        rvalid_r <= 1'b1;
        rresp_r <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_r <= rd_word;
      end
      else if (rready)
        rvalid_r <= 1'b0;
      if (wr_ok && awaddr == REG_CTRL)
        clr_r <= wdata[0];
    end
  end

  // block buffer: filled by reads, drained by writes
  always_ff @(posedge aclk)
  begin
    if (fsm_inc && !wr_type)
      buf_mem[ptr_r] <= drl_val;
    else if (sw_bwr)
      buf_mem[ptr_r] <= wdata[7:0];
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  // byte settles one cycle before its select line; the handshake closes each step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= S_IDLE;
      op_r <= OP_ADDR;
      byte_r <= 8'h00;
      cnt_r <= 9'h000;
      ph_data_r <= 1'b0;
      halt_r <= 1'b0;
      skip_r <= 1'b0;
      busy_r <= 1'b0;
      gap_r <= '0;
      result_r <= 8'h00;
      dal_r <= BUS_IDLE;
      cl_r <= BUS_IDLE;
    end
    else
    begin
      unique case (state_r)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            op_r <= iob_op_t'(wdata[3:0]);
            byte_r <= wdata[15:8];
            cnt_r <= {wdata[15:8] == 8'h00, wdata[15:8]}; // zero means a full page
            ph_data_r <= 1'b0;
            halt_r <= 1'b0;
            skip_r <= 1'b0;
            busy_r <= 1'b1;
            state_r <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          dal_r <= ~cur_byte;
          state_r <= S_DRIVE;
        end
        S_DRIVE:
        begin
          cl_r <= ~(8'h01 << cur_line); // one line only
          state_r <= S_WAIT_SYN;
        end
        S_WAIT_SYN:
        begin
          if (syn_on)
          begin
            if (capture)
              result_r <= drl_val; // keeps following live status
            if (!hold_busy)
            begin
              cl_r <= BUS_IDLE;
              state_r <= S_WAIT_REL;
              if (stat_ph && st_err)
                halt_r <= 1'b1;
            end
          end
        end
        S_WAIT_REL:
        begin
          // no new line until the device has let go
          if (!syn_on)
          begin
            dal_r <= BUS_IDLE;
            if (blk && ph_data_r)
              cnt_r <= cnt_r - 9'h001;
            if (stat_ph && !halt_r)
            begin
              ph_data_r <= 1'b1;
              state_r <= S_SETUP;
            end
            else if (blk && ph_data_r && cnt_r != 9'h001)
            begin
              ph_data_r <= 1'b0; // test status again before each byte
              state_r <= S_SETUP;
            end
            else if (op_r == OP_ADDR)
            begin
              gap_r <= GAP_W'(ADDR_GAP_CYC); // let a former controller drop out
              state_r <= S_GAP;
            end
            else
            begin
              skip_r <= composite && !halt_r;
              busy_r <= 1'b0;
              state_r <= S_IDLE;
            end
          end
        end
        S_GAP:
        begin
          gap_r <= gap_r - 1'b1;
          if (gap_r == GAP_W'(1))
          begin
            busy_r <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence syn_taken;
    state_r == S_WAIT_SYN && syn_on && !hold_busy;
  endsequence
  sequence line_dropped;
    cl_r == BUS_IDLE && state_r == S_WAIT_REL;
  endsequence

  one_line_a: assert property ($countones(~cl_r) <= 1) else $error("two select lines asserted");
  dal_steady_a: assert property (cl_r != BUS_IDLE |-> $stable(dal_r))
    else $error("outbound byte moved under a select line");
  dal_lead_a: assert property (state_r == S_DRIVE |=> cl_r != BUS_IDLE && dal_r == ~$past(cur_byte))
    else $error("select line without its inverted byte");
  drop_line_a: assert property (syn_taken |=> line_dropped)
    else $error("select line held after handshake");
  wait_rel_a: assert property (state_r == S_WAIT_REL && syn_on |=> cl_r == BUS_IDLE)
    else $error("new select line before handshake release");
  ack_only_a: assert property (!cl_r[L_ACK] |-> op_r == OP_ACK)
    else $error("acknowledge line outside acknowledge");
  blk_count_a: assert property (busy_r && blk |-> cnt_r inside {[9'h001 : 9'h100]})
    else $error("block count out of range");
  addr_gap_a: assert property (state_r == S_WAIT_REL && !syn_on && op_r == OP_ADDR |=> busy_r [*8])
    else $error("address gap cut short");
endmodule
`default_nettype wire

// File: inc/iob_pkg.sv
// shared constants, types and register map of the i/o bus host controller
`default_nettype none
package iob_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250; // aclk rate
  localparam int unsigned ADDR_GAP_NS = 350; // deselect time of an old controller
  localparam int unsigned ADDR_GAP_CYC = (ADDR_GAP_NS * CLK_MHZ + 999) / 1000; // rounded up
  localparam int unsigned GAP_W = 8; // width of the gap counter
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_BPTR = 8'h0C;
  localparam logic [7:0] REG_BDATA = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic CTRL_RST = 1'h0; // system clear released
  // ****************************************
  // control line positions on the bus
  // ****************************************
  localparam logic [2:0] L_ADDR = 3'h0;
  localparam logic [2:0] L_CMD = 3'h1;
  localparam logic [2:0] L_DA = 3'h2;
  localparam logic [2:0] L_SR = 3'h3;
  localparam logic [2:0] L_DR = 3'h4;
  localparam logic [2:0] L_ACK = 3'h5; // acknowledge_chain_line
  // status byte: bit n of the byte (msb = bit 0) sits at vector index 7-n
  localparam int SB_BUSY = 3;
  localparam int SB_EX = 2;
  localparam int SB_EOM = 1;
  localparam int SB_DU = 0;
  localparam logic [7:0] BUS_IDLE = 8'hFF; // all lines negated
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {OP_ADDR, OP_CMD, OP_WRITE, OP_STATUS, OP_READ, OP_ACK,
    OP_RDS, OP_WDS, OP_RBLK, OP_WBLK} iob_op_t;
  typedef struct packed {
    logic [7:0] dal_n; // processor_to_device_bus
    logic [7:0] cl_n; // control_select_lines
    logic clear_n; // system_clear_line
  } iob_out_t;
  typedef struct packed {
    logic [7:0] drl_n; // device_to_processor_bus
    logic syn_n; // handshake_return
    logic atn_n; // attention_line
  } iob_in_t;
endpackage
`default_nettype wire

// File: dv/iob_dev_model.sv
// behavioural device controller answering the host on the i/o bus
`default_nettype none
module iob_dev_model
  import iob_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = 8'h5A // strapped address, value arbitrary
)(
  input wire logic aclk,
  input wire logic [3:0] lag, // handshake delay in cycles
  input wire logic [3:0] stat_in, // busy, examine, end of medium, unavailable
  input wire logic [7:0] data_in, // byte for a data request
  input wire logic att_req, // interrupt pending
  input wire logic att_gate, // attention gate flip-flop
  input wire iob_out_t bus_out,
  output iob_in_t bus_in,
  output logic sel_r, // controller selected
  output logic [7:0] cmd_r, // last command byte
  output logic [7:0] da_r // last data byte written
);
  logic [7:0] processor_to_device_bus; // outbound byte, true polarity
  logic [7:0] cl; // select lines, true polarity
  logic hit_ack; // acknowledge stops here
  logic served; // a line is ours to answer
  logic [3:0] wait_r; // cycles waited on the line
  assign processor_to_device_bus = ~bus_out.dal_n;
  assign cl = ~bus_out.cl_n;
  // first in the chain keeps the acknowledge while a request is pending
  assign hit_ack = cl[L_ACK] && att_req;
  assign served = (cl[L_ADDR] && processor_to_device_bus == DEV_ADDR) || (sel_r && |cl[4:1]) || hit_ack;
  // answer after acting on the line, drop at once when it drops
  assign bus_in.syn_n = !(served && wait_r == lag);
  // released lines float high on the load resistors
  assign bus_in.drl_n = (sel_r && cl[L_SR]) ? ~{4'h0, stat_in} : (sel_r && cl[L_DR]) ? ~data_in
    : hit_ack ? ~DEV_ADDR : BUS_IDLE;
  assign bus_in.atn_n = !(att_req && att_gate);
  // select flop and registers; lag must not change mid-line or the answer waits for wait_r to wrap round to it
  always_ff @(posedge aclk)
  begin
    if (!bus_out.clear_n)
    begin
      sel_r <= 1'b0;
      wait_r <= 4'h0;
    end
    else
    begin
      if (cl[L_ADDR])
        sel_r <= processor_to_device_bus == DEV_ADDR;
      if (sel_r && cl[L_CMD])
        cmd_r <= processor_to_device_bus;
      if (sel_r && cl[L_DA])
        da_r <= processor_to_device_bus;
      wait_r <= !served ? 4'h0 : (wait_r == lag) ? wait_r : wait_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking bench: axi master, device model and scoreboard
`default_nettype none
module tb_top import iob_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} iob_exp_t;
  localparam logic [7:0] DEV_ADDR = 8'h5A; // arbitrary strap
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic att_req, att_gate, dev_sel;
  logic [7:0] awaddr, araddr, dev_cmd, dev_da, data_in, b;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb, lag, stat_in;
  logic [1:0] bresp, rresp;
  iob_in_t bus_in;
  iob_out_t bus_out;
  iob_exp_t exp_q[$];
  iob_exp_t cur;
  int failures = 0;
  int n_checks = 0;
  always #2 aclk = ~aclk;
  iob_host_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bus_in(bus_in), .bus_out(bus_out));
  iob_dev_model #(.DEV_ADDR(DEV_ADDR)) dev (.aclk(aclk), .lag(lag), .stat_in(stat_in), .data_in(data_in),
    .att_req(att_req), .att_gate(att_gate), .bus_out(bus_out), .bus_in(bus_in), .sel_r(dev_sel),
    .cmd_r(dev_cmd), .da_r(dev_da));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // write: both channels offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // read: expected word noted under a mask of the bits that matter
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_word = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // polls busy; a device that never answers is caught by the watchdog
  task automatic wait_idle();
    rd_word = 32'h1;
    while (rd_word[0])
      rd(REG_STAT, 32'h0, 32'h0, RESP_OKAY);
  endtask
  task automatic op(input iob_op_t o, input logic [7:0] bt);
    wr(REG_CMD, {16'h0, bt, 4'h0, o}, RESP_OKAY);
    wait_idle();
  endtask
  // scoreboard: each answer retires the oldest note
  always @(posedge aclk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      cur = exp_q.pop_front();
      check({30'h0, bvalid ? bresp : rresp}, {30'h0, cur.r});
      check(rdata & cur.m, cur.d);
    end
  end
  initial
  begin
    repeat (50000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h23bdd335));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, att_req, att_gate} <= '0;
    {awaddr, araddr, data_in, wdata, lag, stat_in} <= '0;
    wstrb <= 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_CTRL, 32'h0, 32'h1, RESP_OKAY);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(8'h44, 32'h1, RESP_SLVERR);
    $display("test registers done");
    op(OP_ADDR, DEV_ADDR);
    check({31'h0, dev_sel}, 32'h1);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'h0, dev_sel}, 32'h0);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    op(OP_ADDR, DEV_ADDR);
    $display("test select done");
    for (int i = 0; i < 5; i++)
    begin
      stat_in <= (i == 4) ? 4'($urandom) : 4'h1 << i;
      lag <= 4'($urandom_range(0, 7));
      data_in <= 8'($urandom);
      b = 8'($urandom);
      @(posedge aclk);
      op(OP_STATUS, 8'h0);
      rd(REG_STAT, {16'h0, 4'h0, stat_in, 8'h0}, 32'hFF00, RESP_OKAY);
      op(OP_READ, 8'h0);
      rd(REG_STAT, {16'h0, data_in, 8'h0}, 32'hFF00, RESP_OKAY);
      op(OP_WRITE, b);
      check({24'h0, dev_da}, {24'h0, b});
      op(OP_CMD, ~b);
      check({24'h0, dev_cmd}, {24'h0, ~b});
    end
    $display("test single steps done");
    stat_in <= 4'h8;
    wr(REG_CMD, {28'h0, OP_RDS}, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(REG_STAT, 32'h1, 32'h1, RESP_OKAY);
    stat_in <= 4'h0;
    wait_idle();
    rd(REG_STAT, {16'h0, data_in, 8'h2}, 32'hFF0A, RESP_OKAY);
    stat_in <= 4'h1;
    @(posedge aclk);
    op(OP_RDS, 8'h0);
    rd(REG_STAT, 32'h0108, 32'hFF0A, RESP_OKAY);
    stat_in <= 4'h0;
    $display("test composite done");
    wr(REG_BPTR, 32'h0, RESP_OKAY);
    op(OP_RBLK, 8'h4);
    rd(REG_STAT, 32'h0, 32'h01FF0000, RESP_OKAY);
    // the block left the index past its last byte, so point back at the first one
    wr(REG_BPTR, 32'h0, RESP_OKAY);
    rd(REG_BDATA, {24'h0, data_in}, 32'hFF, RESP_OKAY);
    wr(REG_BPTR, 32'h20, RESP_OKAY);
    wr(REG_BDATA, {24'h0, b}, RESP_OKAY);
    wr(REG_BDATA, {24'h0, ~b}, RESP_OKAY);
    wr(REG_BPTR, 32'h20, RESP_OKAY);
    op(OP_WBLK, 8'h2);
    check({24'h0, dev_da}, {24'h0, ~b});
    op(OP_WDS, b);
    check({24'h0, dev_da}, {24'h0, b});
    $display("test block done");
    att_req <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(REG_STAT, 32'h0, 32'h4, RESP_OKAY);
    att_gate <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(REG_STAT, 32'h4, 32'h4, RESP_OKAY);
    op(OP_ACK, 8'h0);
    rd(REG_STAT, {16'h0, DEV_ADDR, 8'h0}, 32'hFF00, RESP_OKAY);
    att_req <= 1'b0;
    $display("test attention done");
    report_and_stop();
  end
endmodule
`default_nettype wire
